// file: core/pbo_port_b_override.sv
`timescale 1ns/1ps

module pbo_port_b_override
  import pbo_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] pad_in,
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_dir,
  input wire logic sleeping,
  input wire logic global_irq_en,
  input wire logic pin_change_group0_en,
  input wire logic pin_change_group1_en,
  input wire logic external_irq0_mask,
  input wire logic serial_two_wire,
  input wire logic serial_three_wire,
  input wire logic serial_shift_out_bit,
  input wire logic serial_start_irq_en,
  input wire logic programming_active,
  input wire logic timer1_compare_out_a_en,
  input wire logic timer1_compare_out_a,
  input wire logic counter0_external_clock,
  input wire logic reset_disable_fuse,
  input wire logic bit5_gpio_allowed,
  input wire logic bit4_gpio_allowed,
  input wire logic external_clock_selected,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  output logic [7:0] pullup_en,
  output logic [7:0] din_en,
  output logic pin_change_irq_group0,
  output logic pin_change_irq_group1,
  output logic external_irq0,
  output logic serial_data_in,
  output logic counter0_clock_in,
  output logic ext_clock_in
);

  import pbo_pkg::*;

  pbo_state_t st_r;
  pbo_state_t st_nxt;
  pbo_ovr_t [7:0] ovr;
  pbo_port_t [7:0] port;
  pbo_pad_t [7:0] pad;

  logic reset_pin_function;
  logic serial_on;
  logic pwm_a_on;
  logic pc0_en;
  logic pc1_en;
  logic ext_irq0_en;
  logic [7:0] pc_mask;
  logic [7:0] pc_group1;
  logic [7:0] changed;

  // Unprogrammed fuse (1) keeps the pin as reset input
  assign reset_pin_function = reset_disable_fuse;
  assign serial_on = serial_two_wire | serial_three_wire;
  assign pwm_a_on = timer1_compare_out_a_en & ~programming_active
                    & ~serial_on;
  assign pc0_en = global_irq_en & pin_change_group0_en;
  assign pc1_en = global_irq_en & pin_change_group1_en;
  assign ext_irq0_en = global_irq_en & external_irq0_mask;

  always_comb
  begin
    ovr = '0;
    // Bit 0: three-wire input takes nothing over, hence no term
    ovr[BIT_DATA].pullup_override_en = serial_two_wire;
    ovr[BIT_DATA].pullup_override_val = NO_OVERRIDE;
    ovr[BIT_DATA].dir_override_en = serial_two_wire;
    ovr[BIT_DATA].dir_override_val = (~serial_shift_out_bit
      | ~port_out[BIT_DATA]) & port_dir[BIT_DATA];
    ovr[BIT_DATA].outval_override_en =
      (serial_two_wire & port_dir[BIT_DATA]) | pwm_a_on;
    // Two-wire drives only zero; line released via enable
    ovr[BIT_DATA].outval_override_val =
      ~(serial_two_wire & port_dir[BIT_DATA]) & pwm_a_on
      & ~timer1_compare_out_a;
    ovr[BIT_DATA].din_enable_override_en =
      (~(serial_on | pwm_a_on) & pc0_en) | serial_start_irq_en;
    ovr[BIT_DATA].din_enable_override_val = DIN_FORCE_VAL;

    // Bits 7..4 leave outval overrides at zero
    ovr[BIT_RESET].pullup_override_en = reset_pin_function;
    ovr[BIT_RESET].pullup_override_val = RESET_PULLUP_VAL;
    ovr[BIT_RESET].dir_override_en = reset_pin_function;
    ovr[BIT_RESET].dir_override_val = RESET_DIR_VAL;
    ovr[BIT_RESET].din_enable_override_en =
      pc1_en | reset_pin_function;
    ovr[BIT_RESET].din_enable_override_val =
      pc1_en & ~reset_pin_function;

    ovr[BIT_EXT_IRQ].din_enable_override_en =
      (~counter0_external_clock & pc1_en) | ext_irq0_en;
    ovr[BIT_EXT_IRQ].din_enable_override_val = DIN_FORCE_VAL;

    ovr[BIT_XTAL2].pullup_override_en = ~bit5_gpio_allowed;
    ovr[BIT_XTAL2].pullup_override_val = XTAL_PULLUP_VAL;
    ovr[BIT_XTAL2].dir_override_en = ~bit5_gpio_allowed;
    ovr[BIT_XTAL2].dir_override_val = XTAL_DIR_VAL;
    ovr[BIT_XTAL2].din_enable_override_en =
      pc1_en | ~bit5_gpio_allowed;
    ovr[BIT_XTAL2].din_enable_override_val =
      pc1_en & bit5_gpio_allowed;

    ovr[BIT_XTAL1].pullup_override_en = ~bit4_gpio_allowed;
    ovr[BIT_XTAL1].pullup_override_val = XTAL_PULLUP_VAL;
    ovr[BIT_XTAL1].dir_override_en = ~bit4_gpio_allowed;
    ovr[BIT_XTAL1].dir_override_val = XTAL_DIR_VAL;
    ovr[BIT_XTAL1].din_enable_override_en = pc1_en
      | ~bit4_gpio_allowed | external_clock_selected;
    ovr[BIT_XTAL1].din_enable_override_val =
      (pc1_en & bit4_gpio_allowed) | external_clock_selected;
  end

  always_comb
  begin
    // Masking alternate functions per pin
    pc_mask = '0;
    pc_mask[BIT_DATA] = serial_on | pwm_a_on;
    pc_mask[BIT_RESET] = reset_pin_function;
    pc_mask[BIT_EXT_IRQ] = ext_irq0_en | counter0_external_clock;
    pc_mask[BIT_XTAL2] = ~bit5_gpio_allowed;
    pc_mask[BIT_XTAL1] = ~bit4_gpio_allowed | external_clock_selected;
    pc_group1 = 8'hf0;
  end

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++)
    begin : g_pin
      assign port[g].port_out = port_out[g];
      assign port[g].port_dir = port_dir[g];
      assign port[g].sleeping = sleeping;

      pbo_pin_resolve u_resolve (
        .ovr(ovr[g]),
        .port(port[g]),
        .pad(pad[g])
      );
    end
  endgenerate

  // Edges seen only on pins whose buffer is on
  assign changed = (st_r.sync2 ^ st_r.prev) & st_r.din_en & ~pc_mask;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sync1 = pad_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      st_nxt.pad_out[i] = pad[i].pad_out;
      st_nxt.pad_oe[i] = pad[i].pad_oe;
      st_nxt.pullup_en[i] = pad[i].pullup_en;
      st_nxt.din_en[i] = pad[i].din_en;
    end
    st_nxt.pc_irq0 = pc0_en & (|(changed & ~pc_group1));
    st_nxt.pc_irq1 = pc1_en & (|(changed & pc_group1));
    // Low-level external interrupt on bit 6
    st_nxt.ext_irq0_req = ext_irq0_en & st_r.din_en[BIT_EXT_IRQ]
                          & ~st_r.sync2[BIT_EXT_IRQ];
    // Data input is read with normal port direction in three-wire
    st_nxt.serial_data_in = st_r.sync2[BIT_DATA] & st_r.din_en[BIT_DATA];
    st_nxt.counter0_clock_in = st_r.sync2[BIT_EXT_IRQ]
                               & st_r.din_en[BIT_EXT_IRQ];
    st_nxt.ext_clock_in = st_r.sync2[BIT_XTAL1]
                          & st_r.din_en[BIT_XTAL1];
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_r <= '0;
      st_r.sync1 <= PINS_RESET;
      st_r.sync2 <= PINS_RESET;
      st_r.prev <= PINS_RESET;
      st_r.pc_irq0 <= FLAG_RESET;
      st_r.pc_irq1 <= FLAG_RESET;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  assign pad_out = st_r.pad_out;
  assign pad_oe = st_r.pad_oe;
  assign pullup_en = st_r.pullup_en;
  assign din_en = st_r.din_en;
  assign pin_change_irq_group0 = st_r.pc_irq0;
  assign pin_change_irq_group1 = st_r.pc_irq1;
  assign external_irq0 = st_r.ext_irq0_req;
  assign serial_data_in = st_r.serial_data_in;
  assign counter0_clock_in = st_r.counter0_clock_in;
  assign ext_clock_in = st_r.ext_clock_in;

endmodule // pbo_port_b_override

// file: core/pbo_pkg.sv
package pbo_pkg;

  localparam int PIN_COUNT = 8;

  // Pin positions within port B
  localparam int BIT_DATA = 0;
  localparam int BIT_XTAL1 = 4;
  localparam int BIT_XTAL2 = 5;
  localparam int BIT_EXT_IRQ = 6;
  localparam int BIT_RESET = 7;

  // Fixed override values
  localparam logic RESET_PULLUP_VAL = 1'h1;
  localparam logic RESET_DIR_VAL = 1'h0;
  localparam logic XTAL_PULLUP_VAL = 1'h0;
  localparam logic XTAL_DIR_VAL = 1'h0;
  localparam logic DIN_FORCE_VAL = 1'h1;
  localparam logic NO_OVERRIDE = 1'h0;

  // Values after reset
  localparam logic [7:0] PINS_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'h0;

  // One pin's override controls
  typedef struct packed {
    logic pullup_override_en;
    logic pullup_override_val;
    logic dir_override_en;
    logic dir_override_val;
    logic outval_override_en;
    logic outval_override_val;
    logic din_enable_override_en;
    logic din_enable_override_val;
  } pbo_ovr_t;

  // Ordinary port controls of one pin
  typedef struct packed {
    logic port_out;
    logic port_dir;
    logic sleeping;
  } pbo_port_t;

  // Resolved pad controls of one pin
  typedef struct packed {
    logic pad_out;
    logic pad_oe;
    logic pullup_en;
    logic din_en;
  } pbo_pad_t;

  // Whole state of the override block
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] pullup_en;
    logic [7:0] din_en;
    logic pc_irq0;
    logic pc_irq1;
    logic ext_irq0_req;
    logic serial_data_in;
    logic counter0_clock_in;
    logic ext_clock_in;
  } pbo_state_t;

endpackage

// file: core/pbo_pin_resolve.sv
`timescale 1ns/1ps

module pbo_pin_resolve
  import pbo_pkg::*;
(
  input wire pbo_pkg::pbo_ovr_t ovr,
  input wire pbo_pkg::pbo_port_t port,
  output pbo_pkg::pbo_pad_t pad
);

  always_comb
  begin
    // Ordinary port registers wherever no override is asserted
    pad.pad_out = ovr.outval_override_en ? ovr.outval_override_val
                                         : port.port_out;
    pad.pad_oe = ovr.dir_override_en ? ovr.dir_override_val
                                     : port.port_dir;
    pad.pullup_en = ovr.pullup_override_en ? ovr.pullup_override_val
                    : (port.port_out & ~port.port_dir);
    // Input buffer is gated off in sleep unless overridden
    pad.din_en = ovr.din_enable_override_en ? ovr.din_enable_override_val
                 : ~port.sleeping;
  end

endmodule // pbo_pin_resolve

// file: tb/pbo_port_b_override_assertions.sv
`timescale 1ns/1ps

module pbo_port_b_override_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_dir,
  input wire logic global_irq_en,
  input wire logic serial_two_wire,
  input wire logic serial_three_wire,
  input wire logic serial_shift_out_bit,
  input wire logic programming_active,
  input wire logic timer1_compare_out_a_en,
  input wire logic timer1_compare_out_a,
  input wire logic reset_disable_fuse,
  input wire logic bit5_gpio_allowed,
  input wire logic external_clock_selected,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] din_en,
  input wire logic pin_change_irq_group0,
  input wire logic pin_change_irq_group1
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_tw_pu; ce && serial_two_wire |=> !pullup_en[0]; endproperty
  a_tw_pu: assert property (p_tw_pu) else $error("pull-up on");
  // Released line may show any value; only a driven low is legal
  property p_tw_oe; ce && serial_two_wire |=> (!pad_oe[0] || !pad_out[0])
    && pad_oe[0] == ($past(port_dir[0])
    && !($past(serial_shift_out_bit) && $past(port_out[0])));
  endproperty
  a_tw_oe: assert property (p_tw_oe) else $error("line drive");
  property p_pwm; ce && timer1_compare_out_a_en && port_dir[0] &&
    !(serial_two_wire || serial_three_wire || programming_active) |=>
    pad_oe[0] && pad_out[0] != $past(timer1_compare_out_a);
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm output");
  property p_rst; ce && reset_disable_fuse |=> pullup_en[7] && !pad_oe[7];
  endproperty
  a_rst: assert property (p_rst) else $error("reset pin");
  property p_xtal; ce && !bit5_gpio_allowed |=> !pullup_en[5] && !pad_oe[5];
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal pin");
  property p_xclk; ce && external_clock_selected |=> din_en[4]; endproperty
  a_xclk: assert property (p_xclk) else $error("clock input off");
  property p_hi; ce |=> pad_out[7:4] == $past(port_out[7:4]); endproperty
  a_hi: assert property (p_hi) else $error("upper output");
  // Pipeline of pad sync plus edge flop is drained after five cycles
  property p_gate; (ce && !global_irq_en)[*5] |=>
    !pin_change_irq_group0 && !pin_change_irq_group1; endproperty
  a_gate: assert property (p_gate) else $error("ungated");
  c_tw: cover property (serial_two_wire && !pad_oe[0]);
  c_pc1: cover property (pin_change_irq_group1);
  c_rst: cover property (reset_disable_fuse && pullup_en[7]);
endmodule // pbo_port_b_override_chk

bind pbo_port_b_override pbo_port_b_override_chk u_chk (.*);

// file: tb/pbo_pad_model.sv
`timescale 1ns/1ps

module pbo_pad_model (
  input wire logic clk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] ext_lvl,
  input wire logic [7:0] ext_drv,
  output logic [7:0] pad_in
);
  logic [7:0] last_r;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_drv[i]) pad_in[i] = ext_lvl[i];
      else if (pullup_en[i]) pad_in[i] = 1'h1;
      // Floating pin must not look like a stable level
      else pad_in[i] = ~last_r[i];
  end
  always_ff @(posedge clk) last_r <= pad_in;
endmodule // pbo_pad_model

// file: tb/pbo_port_b_override_tb.sv
`timescale 1ns/1ps

module pbo_port_b_override_tb;
  import pbo_pkg::*;
  logic clk = 1'h0, nrst = 1'h0, ce = 1'h1, sleeping = 1'h0;
  logic [7:0] port_out = 8'hff, port_dir = 8'hff, ext_lvl = 8'h00;
  logic [7:0] ext_drv = 8'hff, pad_in, pad_out, pad_oe, pullup_en, din_en, b0;
  logic global_irq_en = 1'h0, pin_change_group0_en = 1'h0;
  logic pin_change_group1_en = 1'h0, external_irq0_mask = 1'h0;
  logic serial_two_wire = 1'h0, serial_three_wire = 1'h0;
  logic serial_shift_out_bit = 1'h0, serial_start_irq_en = 1'h0;
  logic programming_active = 1'h0;
  logic timer1_compare_out_a_en = 1'h0, timer1_compare_out_a = 1'h0;
  logic counter0_external_clock = 1'h0, reset_disable_fuse = 1'h0;
  logic bit5_gpio_allowed = 1'h1, bit4_gpio_allowed = 1'h1;
  logic external_clock_selected = 1'h0, pin_change_irq_group0;
  logic pin_change_irq_group1, external_irq0, serial_data_in;
  logic counter0_clock_in, ext_clock_in;
  logic [7:0] taps;
  int err_count = 0, num_checks = 0, c0, c1;
  // Two-wire, three-wire, shift, prog, pwm en, pwm, dir, out; then
  // expected pad_out, pad_oe, pull-up of bit 0
  logic [10:0] rows [11] = '{11'h01e, 11'h00d, 11'h518, 11'h41a, 11'h512,
    11'h40c, 11'h20d, 11'h07a, 11'h0d2, 11'h558, 11'h056};

  assign b0 = {5'h00, pad_out[0], pad_oe[0], pullup_en[0]};
  assign taps = {5'h00, serial_data_in, counter0_clock_in, ext_clock_in};
  pbo_port_b_override dut (.*);
  pbo_pad_model u_pads (.*);
  always #10 clk = ~clk;

  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task pulses(input logic [7:0] tog, input logic [7:0] exp);
    @(posedge clk);
    ext_lvl <= ext_lvl ^ tog;
    c0 = 0;
    c1 = 0;
    repeat (8)
    begin
      @(posedge clk);
      #1;
      c0 += (pin_change_irq_group0 === 1'h1);
      c1 += (pin_change_irq_group1 === 1'h1);
    end
    check({c1[3:0], c0[3:0]}, exp);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    settle(8);
    check(pad_oe, 8'h00);
    @(posedge clk) nrst <= 1'h1;
    settle(2);
    check(pad_oe, 8'hff);
    $display("reset done");
    foreach (rows[i])
    begin
      @(posedge clk);
      {serial_two_wire, serial_three_wire, serial_shift_out_bit,
        programming_active, timer1_compare_out_a_en, timer1_compare_out_a,
        port_dir[0], port_out[0]} <= rows[i][10:3];
      settle(2);
      check(b0, {5'h00, rows[i][2:0]});
      $display("row %0d done", i);
    end
    @(posedge clk);
    {serial_two_wire, timer1_compare_out_a_en, reset_disable_fuse} <= 3'h1;
    {bit5_gpio_allowed, bit4_gpio_allowed, external_clock_selected} <= 3'h1;
    {port_dir, port_out, sleeping, global_irq_en} <= {8'hf0, 8'hff, 2'h3};
    pin_change_group1_en <= 1'h1;
    settle(2);
    check({pad_oe[7:4], pullup_en[7:4]}, 8'h48);
    check({pad_out[7:4], din_en[7:4]}, 8'hf5);
    @(posedge clk);
    {reset_disable_fuse, bit5_gpio_allowed, bit4_gpio_allowed} <= 3'h3;
    {external_clock_selected, pin_change_group0_en} <= 2'h1;
    settle(2);
    // No override on bits 3..1, so sleep keeps their buffers off
    check(din_en, 8'hf1);
    check(pad_oe, 8'hf0);
    @(posedge clk) serial_two_wire <= 1'h1;
    settle(2);
    check(din_en, 8'hf0);
    @(posedge clk) serial_start_irq_en <= 1'h1;
    settle(2);
    check(din_en, 8'hf1);
    $display("fuse and sleep done");
    // Awake so bits 3..1 see edges; released pins settle first
    @(posedge clk) {port_dir, serial_start_irq_en, sleeping} <= 10'h000;
    settle(8);
    pulses(8'h80, 8'h10);
    pulses(8'h08, 8'h01);
    pulses(8'h01, 8'h00);
    @(posedge clk) reset_disable_fuse <= 1'h1;
    pulses(8'h80, 8'h00);
    @(posedge clk) global_irq_en <= 1'h0;
    pulses(8'h08, 8'h00);
    $display("pin change done");
    @(posedge clk) {global_irq_en, external_irq0_mask} <= 2'h3;
    settle(5);
    check({7'h00, external_irq0}, 8'h01);
    @(posedge clk) external_irq0_mask <= 1'h0;
    settle(5);
    check({7'h00, external_irq0}, 8'h00);
    @(posedge clk) {ce, port_dir} <= {1'h0, 8'hff};
    settle(3);
    check(pad_oe, 8'h00);
    @(posedge clk) ce <= 1'h1;
    settle(2);
    check(pad_oe, 8'h7f);
    $display("irq and freeze done");
    @(posedge clk) {port_dir, ext_lvl} <= {8'h00, 8'h51};
    settle(5);
    check(taps, 8'h07);
    // Asleep: of the tapped pins only the forced clock input (bit 4) keeps its buffer on
    @(posedge clk) {sleeping, counter0_external_clock} <= 2'h3;
    external_clock_selected <= 1'h1;
    settle(3);
    check(taps, 8'h01);
    $display("pin data done");
    finish_test;
  end
endmodule // pbo_port_b_override_tb
